// >>> src/osd_char_pkg.sv
// constants, types and register map of the character-attribute block
package osd_char_pkg;

    // ----------
    // geometry
    // ----------
    localparam int ROWS = 12;
    localparam int COLS = 32;
    localparam int CELLS = 384;
    localparam int GLYPHS = 384;
    localparam int GLYPH_W = 12;
    localparam int GLYPH_H = 18;
    localparam int GLYPH_WORDS = 32;
    localparam int FONT_WORDS = GLYPHS * GLYPH_WORDS;
    localparam int ADDR_W = 15;

    // ----------
    // word addresses on the register port
    // ----------
    localparam logic [14:0] TEXT_BASE = 15'h0000;
    localparam logic [14:0] REG_SCREEN = 15'h0200;
    localparam logic [14:0] REG_DIGOUT = 15'h0201;
    localparam logic [14:0] REG_FORMAT = 15'h0202;
    localparam logic [14:0] FONT_BASE = 15'h4000;

    // ----------
    // field positions
    // ----------
    localparam int BLINK_BIT = 15;
    localparam int SHADE_CURSOR_BIT = 14;
    localparam int BTN_HI = 13;
    localparam int BTN_LO = 12;
    localparam int COLOUR_HI = 11;
    localparam int COLOUR_LO = 9;
    localparam int CODE_HI = 8;
    localparam int SCR_MODE_BIT = 0;
    localparam int SCR_BLINK_PER_BIT = 1;
    localparam int SCR_CURSOR_SAT_BIT = 2;
    localparam int DOUT_BLINK_BIT = 4;
    localparam int DOUT_FULL_BIT = 6;
    localparam int FMT_VIOL_BIT = 0;
    localparam int FMT_SYNC_BIT = 1;
    localparam int FMT_LOAD_BIT = 2;
    localparam int FONT_MSB_DOT = 15;

    // ----------
    // reset values, levels, counts
    // ----------
    localparam logic [2:0] SCREEN_RST = 3'h0;
    localparam logic [1:0] DIGOUT_RST = 2'h0;
    localparam logic [6:0] BTN_LIGHT_IRE = 7'h4B;
    localparam logic [6:0] BTN_DARK_IRE = 7'h0F;
    localparam logic [6:0] PEDESTAL_IRE = 7'h05;
    localparam int BLINK_SHORT_FIELDS = 32;
    localparam int BLINK_LONG_FIELDS = 64;

    typedef enum logic [1:0] {
        BTN_NONE = 2'h0,
        BTN_START = 2'h1,
        BTN_END = 2'h2,
        BTN_SINGLE = 2'h3
    } button_code_e;

    typedef enum logic [2:0] {
        CP_IDLE = 3'h1,
        CP_WAIT = 3'h2,
        CP_RUN = 3'h4
    } copy_state_e;

    typedef struct packed {
        logic [3:0] row;
        logic [4:0] col;
        logic [4:0] line;
        logic [3:0] dot;
    } cell_pos_s;

    typedef struct packed {
        logic button_lowered;
        logic double_size;
        logic [2:0] cursor_colour;
        logic cursor_bright;
    } row_attr_s;

    typedef struct packed {
        logic char_on;
        logic [2:0] colour;
        logic halftone_on;
        logic cursor_on;
        logic [2:0] cursor_colour;
        logic shade_level;
        logic button_on;
        logic [6:0] button_ire;
    } cv_pix_s;

    typedef struct packed {
        logic char_pixel_digital_out;
        logic display_region_digital_out;
        logic red_colour_bit;
        logic green_colour_bit;
        logic blue_colour_bit;
    } dig_pix_s;

endpackage

// >>> src/osd_char_attr.sv
// character-unit attribute, font lookup and double-buffered text ram of the display
`timescale 1ns/100ps
// Function
// R1 - three-bit colour code drives digital r/g/b
// R2 - superimposed: halftone bit dims video behind cell
// R3 - text mode: halftone bit fills cursor colour
// R4 - mode select picks halftone or cursor meaning
// R5 - blink attribute blinks composite, two periods
// R6 - digital blink needs enable and attribute both
// R7 - blinking hides character pixels, never frame
// R8 - button frame replaces outer dots of cell
// R9 - double size rows get two-dot frame; code draws a one-dot frame in every row
// R10 - frame light 75, dark 15 IRE levels
// R11 - many horizontal buttons, one row style
// R12 - software marks button start and end cells
// R13 - 384 glyphs, code zero always blank
// R14 - cell code fetches font row per line
// R15 - software stores glyph in 16x32 block
// R16 - 384 words with fixed attribute fields
// R17 - cpu uses master, display uses slave
// R18 - load request copies now or at vsync
// R19 - load request reads one until copy done
// R20 - master access during copy ignored, flagged
// R21 - software polls request and reinitialises ram
// R22 - master stays accessible in module stop
// R23 - full-content select outputs cursor colour
// R24 - button code meanings and row style bit
// R25 - software uses codes up to 17F only
// R26 - slave copy holds image between transfers
module osd_char_attr
    import osd_char_pkg::*;
#(
    parameter int BLINK_SHORT = BLINK_SHORT_FIELDS,
    parameter int BLINK_LONG = BLINK_LONG_FIELDS
) (
    input wire logic ref_clk, // 20 MHz system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic [ADDR_W-1:0] addr, // word address
    input wire logic [15:0] wr_data, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [15:0] rd_data, // read data, cycle after rd_en
    input wire logic vsync_pin, // vertical sync from sync separator
    input wire logic module_stop, // display module stopped
    input wire logic dot_en, // one-cycle pulse per displayed dot
    input wire logic dot_active, // dot lies inside the character area
    input wire cell_pos_s dot_pos, // cell and dot under the beam
    input wire row_attr_s row_attr, // attributes of the current row
    output cv_pix_s cv_pix, // composite-side pixel attributes
    output dig_pix_s dig_pix, // digital r/g/b and region outputs
    output logic cursor_sat, // whole-screen cursor saturation
    output logic load_busy // copy pending or running
);

    initial begin
        if (BLINK_SHORT < 1 || BLINK_SHORT > 255 || BLINK_LONG < 1 || BLINK_LONG > 255) begin
            $error("blink field counts must lie in 1..255");
        end
    end

    // ----------
    // storage
    // ----------
    logic [15:0] master_ram [0:CELLS-1];
    logic [15:0] slave_ram [0:CELLS-1];
    logic [15:0] font_rom [0:FONT_WORDS-1];

    logic [2:0] screen_ctl;
    logic [1:0] digout_ctl;
    logic sync_update_bit;
    logic access_violation_flag;
    copy_state_e copy_state;
    copy_state_e next_copy_state;

    wire logic display_mode_select = screen_ctl[SCR_MODE_BIT];
    wire logic blink_long_sel = screen_ctl[SCR_BLINK_PER_BIT];
    wire logic digital_blink_enable = digout_ctl[0];
    wire logic digital_full_content_select = digout_ctl[1];
    wire logic load_request_bit = (copy_state != CP_IDLE);

    // ----------
    // address decode
    // ----------
    wire logic hit_text = (addr < 15'(CELLS));
    wire logic hit_font = (addr >= FONT_BASE) && (addr < FONT_BASE + 15'(FONT_WORDS));
    wire logic [13:0] font_idx = 14'(addr - FONT_BASE);
    wire logic [8:0] text_idx = addr[8:0];
    wire logic master_access = (wr_en || rd_en) && hit_text;
    wire logic master_ok = master_access && !load_request_bit; // [R20] [R22]
    wire logic fmt_wr = wr_en && (addr == REG_FORMAT);
    wire logic load_start = fmt_wr && wr_data[FMT_LOAD_BIT] && !load_request_bit;

    // ----------
    // vsync synchroniser and edge
    // ----------
    logic vs_meta, vs_sync, vs_last;
    wire logic vs_pulse = vs_sync && !vs_last;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vs_meta <= 1'b0;
            vs_sync <= 1'b0;
            vs_last <= 1'b0;
        end else begin
            vs_meta <= vsync_pin;
            vs_sync <= vs_meta;
            vs_last <= vs_sync;
        end
    end

    // ----------
    // control registers
    // ----------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            screen_ctl <= SCREEN_RST;
            digout_ctl <= DIGOUT_RST;
            sync_update_bit <= 1'b0;
        end else if (wr_en) begin
            if (addr == REG_SCREEN) begin
                screen_ctl <= wr_data[2:0];
            end
            if (addr == REG_DIGOUT) begin
                digout_ctl <= {wr_data[DOUT_FULL_BIT], wr_data[DOUT_BLINK_BIT]};
            end
            if (fmt_wr) begin
                sync_update_bit <= wr_data[FMT_SYNC_BIT];
            end
        end
    end

    // set wins over a same-cycle clear by writing zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            access_violation_flag <= 1'b0;
        end else if (master_access && load_request_bit) begin
            access_violation_flag <= 1'b1; // [R20]
        end else if (fmt_wr && !wr_data[FMT_VIOL_BIT]) begin
            access_violation_flag <= 1'b0;
        end
    end

    // ----------
    // cpu side of master ram, font store and read data
    // ----------
    always_ff @(posedge ref_clk) begin
        if (wr_en && master_ok) begin
            master_ram[text_idx] <= wr_data; // [R17]
        end
        // glyph zero is never written, so it cannot be redefined
        if (wr_en && hit_font && font_idx[13:5] != 9'h000) begin
            font_rom[font_idx] <= wr_data; // [R13]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            if (hit_text) begin
                rd_data <= master_ok ? master_ram[text_idx] : 16'h0000; // [R20]
            end else if (hit_font) begin
                rd_data <= (font_idx[13:5] == 9'h000) ? 16'h0000 : font_rom[font_idx];
            end else if (addr == REG_SCREEN) begin
                rd_data <= {13'h0000, screen_ctl};
            end else if (addr == REG_DIGOUT) begin
                rd_data <= {9'h000, digout_ctl[1], 1'b0, digout_ctl[0], 4'h0};
            end else if (addr == REG_FORMAT) begin
                rd_data <= {13'h0000, load_request_bit, sync_update_bit,
                    access_violation_flag}; // [R19]
            end else begin
                rd_data <= 16'h0000;
            end
        end
    end

    // ----------
    // master to slave copy
    // ----------
    logic [8:0] cp_rd_idx, cp_wr_idx;
    logic cp_rd_v, cp_wr_v;
    logic [15:0] cp_data;
    wire logic cp_last = cp_wr_v && (cp_wr_idx == 9'(CELLS - 1));

    always_comb begin
        next_copy_state = copy_state;
        case (copy_state)
            CP_IDLE: begin
                if (load_start) begin
                    next_copy_state = wr_data[FMT_SYNC_BIT] ? CP_WAIT : CP_RUN; // [R18]
                end
            end
            CP_WAIT: begin
                if (vs_pulse) begin
                    next_copy_state = CP_RUN; // [R18]
                end
            end
            CP_RUN: begin
                if (cp_last) begin
                    next_copy_state = CP_IDLE; // [R19]
                end
            end
            default: begin
                next_copy_state = CP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            copy_state <= CP_IDLE;
        end else begin
            copy_state <= next_copy_state;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cp_rd_idx <= 9'h000;
            cp_rd_v <= 1'b0;
            cp_wr_idx <= 9'h000;
            cp_wr_v <= 1'b0;
        end else begin
            cp_wr_v <= cp_rd_v;
            cp_wr_idx <= cp_rd_idx;
            if (copy_state != CP_RUN && next_copy_state == CP_RUN) begin
                cp_rd_idx <= 9'h000;
                cp_rd_v <= 1'b1;
            end else if (cp_rd_v) begin
                if (cp_rd_idx == 9'(CELLS - 1)) begin
                    cp_rd_v <= 1'b0;
                end else begin
                    cp_rd_idx <= cp_rd_idx + 9'h001;
                end
            end
        end
    end

    // the slave is written only by the copy, so it holds the last image
    always_ff @(posedge ref_clk) begin
        cp_data <= master_ram[cp_rd_idx];
        if (cp_wr_v) begin
            slave_ram[cp_wr_idx] <= cp_data; // [R17] [R26]
        end
    end

    // ----------
    // blink timing, counted in fields
    // ----------
    logic [7:0] blink_cnt;
    logic blink_hidden;
    wire logic [7:0] blink_top = blink_long_sel ? 8'(BLINK_LONG - 1) : 8'(BLINK_SHORT - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blink_cnt <= 8'h00;
            blink_hidden <= 1'b0;
        end else if (vs_pulse) begin
            if (blink_cnt >= blink_top) begin
                blink_cnt <= 8'h00;
                blink_hidden <= !blink_hidden; // [R5]
            end else begin
                blink_cnt <= blink_cnt + 8'h01;
            end
        end
    end

    // ----------
    // display pipeline: slave word, then font row, then pixel
    // ----------
    logic a_v, b_v, b_blank, btn_open;
    cell_pos_s a_pos, b_pos;
    row_attr_s a_attr, b_attr;
    logic [15:0] a_word, b_word, b_font;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            a_v <= 1'b0;
            a_pos <= '0;
            a_attr <= '0;
            b_v <= 1'b0;
            b_pos <= '0;
            b_attr <= '0;
            b_word <= 16'h0000;
            b_blank <= 1'b1;
        end else begin
            a_v <= dot_en && dot_active && !module_stop;
            a_pos <= dot_pos;
            a_attr <= row_attr;
            b_v <= a_v;
            b_pos <= a_pos;
            b_attr <= a_attr;
            b_word <= a_word;
            b_blank <= (a_word[CODE_HI:0] == 9'h000); // [R13]
        end
    end

    always_ff @(posedge ref_clk) begin
        a_word <= slave_ram[{dot_pos.row, dot_pos.col}]; // [R17]
        b_font <= font_rom[{a_word[CODE_HI:0], a_pos.line}]; // [R14]
    end

    // ----------
    // per-dot attribute evaluation
    // ----------
    logic [1:0] b_btn;
    logic [2:0] colour, rgb_next;
    logic open_now, has_tb, has_l, has_r, e_top, e_bot, e_left, e_right;
    logic edge_a, edge_b, frame_on, frame_light, glyph_px, cv_char, dig_char;
    logic blink_attr_bit, halftone_or_cursor_bit;

    always_comb begin
        b_btn = b_word[BTN_HI:BTN_LO];
        blink_attr_bit = b_word[BLINK_BIT];
        halftone_or_cursor_bit = b_word[SHADE_CURSOR_BIT]; // [R16]
        colour = b_word[COLOUR_HI:COLOUR_LO]; // [R16]
        open_now = btn_open && (b_pos.col != 5'h00);
        // frame edges are one dot and one line wide in every row; double_size is never read
        e_top = (b_pos.line == 5'h00); // [R9]
        e_bot = (b_pos.line == 5'(GLYPH_H - 1)); // [R9]
        e_left = (b_pos.dot == 4'h0); // [R8]
        e_right = (b_pos.dot == 4'(GLYPH_W - 1)); // [R8]
        has_tb = (b_btn != BTN_NONE) || open_now; // [R24] [R11]
        has_l = (b_btn == BTN_START) || (b_btn == BTN_SINGLE); // [R24]
        has_r = (b_btn == BTN_END) || (b_btn == BTN_SINGLE); // [R24]
        edge_a = (has_tb && e_top) || (has_l && e_left);
        edge_b = ((has_tb && e_bot) || (has_r && e_right)) && !edge_a;
        frame_on = edge_a || edge_b; // [R8]
        // raised: top and left light; lowered: the reverse
        frame_light = b_attr.button_lowered ? edge_b : edge_a; // [R11] [R24]
        glyph_px = !b_blank && b_font[4'(FONT_MSB_DOT) - b_pos.dot] && !frame_on; // [R8]
        cv_char = glyph_px && !(blink_attr_bit && blink_hidden); // [R5] [R7]
        dig_char = glyph_px && !(digital_blink_enable && blink_attr_bit && blink_hidden); // [R6]
        rgb_next = (digital_full_content_select && halftone_or_cursor_bit)
            ? b_attr.cursor_colour : (dig_char ? colour : 3'h0); // [R1] [R23]
    end

    // button run of a row: opened by a start cell, closed after an end cell
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            btn_open <= 1'b0;
        end else if (b_v && e_right && e_bot) begin
            if (b_btn == BTN_START) begin
                btn_open <= 1'b1; // [R12]
            end else if (b_btn == BTN_END || b_btn == BTN_SINGLE) begin
                btn_open <= 1'b0; // [R12]
            end else begin
                btn_open <= open_now;
            end
        end
    end

    // ----------
    // outputs
    // ----------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cv_pix <= '0;
        end else if (b_v) begin
            cv_pix.char_on <= cv_char; // [R5]
            cv_pix.colour <= colour;
            cv_pix.halftone_on <= !display_mode_select && halftone_or_cursor_bit
                && !glyph_px; // [R2] [R4]
            cv_pix.cursor_on <= display_mode_select && halftone_or_cursor_bit
                && !glyph_px && !frame_on; // [R3] [R4]
            cv_pix.cursor_colour <= b_attr.cursor_colour; // [R3]
            cv_pix.shade_level <= b_attr.cursor_bright; // [R2] [R3]
            cv_pix.button_on <= frame_on; // [R7]
            cv_pix.button_ire <= frame_light ? BTN_LIGHT_IRE
                : (frame_on ? BTN_DARK_IRE : PEDESTAL_IRE); // [R10]
        end else if (module_stop || (dot_en && !dot_active)) begin
            cv_pix <= '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dig_pix <= '0;
        end else if (b_v) begin
            dig_pix.char_pixel_digital_out <= dig_char; // [R6]
            dig_pix.display_region_digital_out <= 1'b1; // [R6]
            {dig_pix.red_colour_bit, dig_pix.green_colour_bit, dig_pix.blue_colour_bit}
                <= rgb_next; // [R1] [R23]
        end else if (module_stop || (dot_en && !dot_active)) begin
            dig_pix <= '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cursor_sat <= 1'b0;
            load_busy <= 1'b0;
        end else begin
            cursor_sat <= screen_ctl[SCR_CURSOR_SAT_BIT]; // [R3]
            load_busy <= (next_copy_state != CP_IDLE); // [R19]
        end
    end

endmodule // osd_char_attr

// >>> sim/osd_char_attr_props.sv
// assertion checker for the character-attribute block
`timescale 1ns/100ps
module osd_char_attr_props
    import osd_char_pkg::*;
#(
    parameter int BLINK_SHORT = BLINK_SHORT_FIELDS,
    parameter int BLINK_LONG = BLINK_LONG_FIELDS
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [ADDR_W-1:0] addr, // address
    input wire logic [15:0] wr_data, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [15:0] rd_data, // read data
    input wire logic module_stop, // stop
    input wire logic dot_en, // dot strobe
    input wire cv_pix_s cv_pix, // composite pixel
    input wire logic cursor_sat, // saturation
    input wire logic load_busy // copy busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic sync_sel;
    logic sat_w;
    // shadows of the sync-update and saturation bits, as software last wrote them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_sel <= 1'b0;
            sat_w <= 1'b0;
        end else if (wr_en && addr == REG_FORMAT) begin
            sync_sel <= wr_data[FMT_SYNC_BIT];
        end else if (wr_en && addr == REG_SCREEN) begin
            sat_w <= wr_data[SCR_CURSOR_SAT_BIT];
        end
    end
    sequence s_text_rd_in_copy;
        rd_en && addr <= 15'h017F && load_busy ##1 load_busy;
    endsequence
    sequence s_copy_now;
        $rose(load_busy) && !sync_sel;
    endsequence
    a_viol_read_zero: assert property (s_text_rd_in_copy |-> rd_data == 16'h0000)
        else $error("text read during copy not refused");
    a_copy_length: assert property (s_copy_now |-> ##[370:400] $fell(load_busy))
        else $error("immediate copy length wrong");
    a_busy_start: assert property (wr_en && addr == REG_FORMAT && wr_data[FMT_LOAD_BIT]
        && !load_busy |-> ##[1:3] load_busy)
        else $error("load request did not start copy");
    a_glyph0_blank: assert property (rd_en && addr >= FONT_BASE && addr <= 15'h401F
        |=> rd_data == 16'h0000)
        else $error("glyph zero not blank");
    a_mode_excl: assert property (!(cv_pix.halftone_on && cv_pix.cursor_on))
        else $error("halftone and cursor both on");
    a_button_ire: assert property (cv_pix.button_on |->
        cv_pix.button_ire == BTN_LIGHT_IRE || cv_pix.button_ire == BTN_DARK_IRE)
        else $error("frame level wrong");
    a_stop_blank: assert property (module_stop [*5] |-> cv_pix == '0)
        else $error("pixels not blanked in stop");
    a_pipe_lat: assert property (!$stable(cv_pix) |-> $past(dot_en, 3) || $past(dot_en)
        || $past(module_stop)
        || $past(module_stop, 2) || $past(module_stop, 3))
        else $error("pixel change without dot");
    a_sat_track: assert property ($past(sat_w) == sat_w && $past(sat_w, 2) == sat_w
        |-> cursor_sat == sat_w)
        else $error("cursor saturation wrong");
endmodule // osd_char_attr_props
bind osd_char_attr osd_char_attr_props #(.BLINK_SHORT(BLINK_SHORT), .BLINK_LONG(BLINK_LONG))
    i_osd_char_attr_props (.ref_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .module_stop, .dot_en, .cv_pix, .cursor_sat, .load_busy);

// >>> sim/osd_host_model.sv
// register-port master standing in for the host processor
`timescale 1ns/100ps
module osd_host_model
    import osd_char_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic [15:0] rd_data, // read data
    output logic [ADDR_W-1:0] addr, // word address
    output logic [15:0] wr_data, // write data
    output logic wr_en, // write strobe
    output logic rd_en // read strobe
);
    initial begin
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        // released data bus must not keep the last value
        wr_data <= ~d;
    endtask
    task automatic rd(input logic [14:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        d = rd_data;
    endtask
    task automatic poll_idle(output logic [15:0] d);
        int n;
        n = 0;
        do begin
            rd(REG_FORMAT, d);
            n++;
        end while (d[FMT_LOAD_BIT] !== 1'b0 && n < 400);
    endtask
endmodule // osd_host_model

// >>> sim/osd_char_attr_tb.sv
// self-checking testbench of the character-attribute block
`timescale 1ns/100ps
module osd_char_attr_tb;
    import osd_char_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [15:0] rd_data;
    logic vsync_pin = 1'b0;
    logic module_stop = 1'b0;
    logic dot_en = 1'b0;
    logic dot_active = 1'b0;
    cell_pos_s dot_pos = '0;
    row_attr_s row_attr = '{1'b0, 1'b0, 3'h6, 1'b0};
    cv_pix_s cv_pix;
    dig_pix_s dig_pix;
    logic cursor_sat;
    logic load_busy;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    // short blink counts keep the run brief
    osd_char_attr #(.BLINK_SHORT(2), .BLINK_LONG(3)) i_osd_char_attr (.ref_clk, .rst, .addr,
        .wr_data, .wr_en, .rd_en, .rd_data, .vsync_pin, .module_stop, .dot_en, .dot_active,
        .dot_pos, .row_attr, .cv_pix, .dig_pix, .cursor_sat, .load_busy);
    osd_host_model i_osd_host_model (.ref_clk, .rd_data, .addr, .wr_data, .wr_en, .rd_en);
    always #25 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        i_osd_host_model.wr(a, d);
    endtask
    task automatic copy_now();
        logic [15:0] d;
        wr(REG_FORMAT, 16'h0004);
        i_osd_host_model.poll_idle(d);
    endtask
    task automatic vpulse();
        @(posedge ref_clk);
        vsync_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        vsync_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // one dot of row 0, column 1; result read once the pipeline has settled
    task automatic dot(input logic [4:0] l, input logic [3:0] x);
        @(posedge ref_clk);
        dot_pos <= '{4'h0, 5'h01, l, x};
        dot_en <= 1'b1;
        dot_active <= 1'b1;
        @(posedge ref_clk);
        dot_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    function automatic logic [15:0] rgb();
        return {13'h0, dig_pix.red_colour_bit, dig_pix.green_colour_bit, dig_pix.blue_colour_bit};
    endfunction
    task automatic t_regs();
        logic [15:0] d;
        wr(TEXT_BASE + 15'h0005, 16'hA5C3);
        i_osd_host_model.rd(TEXT_BASE + 15'h0005, d);
        chk16(d, 16'hA5C3);
        wr(FONT_BASE, 16'hFFFF);
        i_osd_host_model.rd(FONT_BASE, d);
        chk16(d, 16'h0000);
        wr(FONT_BASE + 15'h0020, 16'h800F);
        wr(FONT_BASE + 15'h0025, 16'h000F);
        i_osd_host_model.rd(FONT_BASE + 15'h0020, d);
        chk16(d, 16'h800F);
        i_osd_host_model.rd(15'h0300, d);
        chk16(d, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_copy();
        logic [15:0] d;
        wr(REG_FORMAT, 16'h0004);
        i_osd_host_model.rd(REG_FORMAT, d);
        chk16(d & 16'h0004, 16'h0004);
        wr(TEXT_BASE + 15'h0005, 16'h1111);
        i_osd_host_model.rd(TEXT_BASE + 15'h0005, d);
        chk16(d, 16'h0000);
        i_osd_host_model.poll_idle(d);
        chk16(d & 16'h0007, 16'h0001);
        i_osd_host_model.rd(TEXT_BASE + 15'h0005, d);
        chk16(d, 16'hA5C3);
        wr(REG_FORMAT, 16'h0006);
        repeat (30) @(posedge ref_clk);
        i_osd_host_model.rd(REG_FORMAT, d);
        chk16(d & 16'h0004, 16'h0004);
        vpulse();
        i_osd_host_model.poll_idle(d);
        chk16(d & 16'h0005, 16'h0000);
        $display("test copy done");
    endtask
    task automatic t_pixels();
        for (int c = 0; c < 8; c++) begin
            wr(TEXT_BASE + 15'h0001, {4'h0, 3'(c), 9'h001});
            copy_now();
            dot(5'h00, 4'h0);
            chk16(rgb(), 16'(c));
        end
        wr(TEXT_BASE + 15'h0001, {4'h0, 3'h2, 9'h001});
        dot(5'h00, 4'h0);
        chk16(rgb(), 16'h0007);
        wr(TEXT_BASE + 15'h0001, 16'h7201);
        copy_now();
        dot(5'h05, 4'h5);
        chk16({14'h0, cv_pix.halftone_on, cv_pix.cursor_on}, 16'h0002);
        dot(5'h00, 4'h0);
        chk16({14'h0, cv_pix.button_on, cv_pix.char_on}, 16'h0002);
        wr(REG_SCREEN, 16'h0005);
        dot(5'h05, 4'h5);
        chk16({11'h0, cv_pix.halftone_on, cv_pix.cursor_on, cv_pix.cursor_colour}, 16'h000E);
        wr(REG_DIGOUT, 16'h0050);
        dot(5'h05, 4'h5);
        chk16(rgb(), 16'h0006);
        wr(TEXT_BASE + 15'h0001, 16'h8201);
        copy_now();
        vpulse();
        vpulse();
        dot(5'h00, 4'h0);
        chk16({14'h0, dig_pix.char_pixel_digital_out, dig_pix.display_region_digital_out},
            16'h0001);
        $display("test pixels done");
    endtask
    task automatic t_stop();
        logic [15:0] d;
        module_stop <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wr(TEXT_BASE + 15'h0005, 16'h2222);
        i_osd_host_model.rd(TEXT_BASE + 15'h0005, d);
        chk16(d, 16'h2222);
        module_stop <= 1'b0;
        $display("test stop done");
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_copy();
        t_pixels();
        t_stop();
        print_verdict();
    end
endmodule // osd_char_attr_tb
